// ==== tap_pkg.sv ====
// shared constants and types for the test and emulation access port
package tap_pkg;
  localparam int IR_LEN = 4;
  localparam logic [3:0] IR_RESET = 4'h1;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_EMUCTL = 4'h2;
  localparam int EMUCTL_LEN = 2;
  localparam logic [1:0] EMUCTL_RESET = 2'h0;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
    UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst;
  } jtag_in_t;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;
endpackage : tap_pkg

// ==== sync2.sv ====
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = rst ? '0 : d;
    next_q = rst ? '0 : meta;
  end

  always_ff @(posedge mclk) begin
    meta <= next_meta;
    q <= next_q;
  end
endmodule : sync2

// ==== jtag_emulation_test_port.sv ====
// scan access port: tap controller, instruction and data paths, emulator pins and output disable
`timescale 1ns/100ps
module jtag_emulation_test_port (
  input wire logic mclk,
  input wire logic rst,
  input wire tap_pkg::jtag_in_t jtag_in,
  input wire logic emulator_event_pin_zero_in,
  input wire logic emulator_event_pin_one_in,
  input wire logic [1:0] emu_event_out,
  output logic tdo_o,
  output logic tdo_oe,
  output logic emulator_event_pin_zero_o,
  output logic emulator_event_pin_zero_oe,
  output logic emulator_event_pin_one_o,
  output logic emulator_event_pin_one_oe,
  output logic [1:0] emu_event_in,
  output logic outputs_off,
  output logic scan_active
);
  tap_pkg::jtag_in_t js;
  logic e0s;
  logic e1s;
  sync2 #(.W(6)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({jtag_in, emulator_event_pin_zero_in, emulator_event_pin_one_in}),
    .q({js, e0s, e1s})
  );

  logic tck_d;
  logic next_tck_d;
  logic tck_rise;
  logic tck_fall;
  assign tck_rise = js.tck & ~tck_d;
  assign tck_fall = ~js.tck & tck_d;

  tap_pkg::tap_state_t state;
  tap_pkg::tap_state_t next_state;
  logic [tap_pkg::IR_LEN-1:0] ir_sh;
  logic [tap_pkg::IR_LEN-1:0] ir;
  logic [tap_pkg::EMUCTL_LEN-1:0] ctl_sh;
  logic [tap_pkg::EMUCTL_LEN-1:0] emu_dir;
  logic byp;
  logic [tap_pkg::IR_LEN-1:0] next_ir_sh;
  logic [tap_pkg::IR_LEN-1:0] next_ir;
  logic [tap_pkg::EMUCTL_LEN-1:0] next_ctl_sh;
  logic [tap_pkg::EMUCTL_LEN-1:0] next_emu_dir;
  logic next_byp;
  logic tdo;
  logic tdo_en;
  logic next_tdo;
  logic next_tdo_en;
  logic [1:0] next_emu_event_in;
  logic next_outputs_off;
  logic next_scan_active;
  logic next_e0_o;
  logic next_e0_oe;
  logic next_e1_o;
  logic next_e1_oe;

  function automatic tap_pkg::tap_state_t tap_step(input tap_pkg::tap_state_t s, input logic tms);
    unique case (s)
      tap_pkg::TEST_LOGIC_RESET: tap_step = tms ? tap_pkg::TEST_LOGIC_RESET : tap_pkg::RUN_TEST_IDLE;
      tap_pkg::RUN_TEST_IDLE: tap_step = tms ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
      tap_pkg::SELECT_DR: tap_step = tms ? tap_pkg::SELECT_IR : tap_pkg::CAPTURE_DR;
      tap_pkg::CAPTURE_DR: tap_step = tms ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      tap_pkg::SHIFT_DR: tap_step = tms ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      tap_pkg::EXIT1_DR: tap_step = tms ? tap_pkg::UPDATE_DR : tap_pkg::PAUSE_DR;
      tap_pkg::PAUSE_DR: tap_step = tms ? tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
      tap_pkg::EXIT2_DR: tap_step = tms ? tap_pkg::UPDATE_DR : tap_pkg::SHIFT_DR;
      tap_pkg::UPDATE_DR: tap_step = tms ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
      tap_pkg::SELECT_IR: tap_step = tms ? tap_pkg::TEST_LOGIC_RESET : tap_pkg::CAPTURE_IR;
      tap_pkg::CAPTURE_IR: tap_step = tms ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      tap_pkg::SHIFT_IR: tap_step = tms ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      tap_pkg::EXIT1_IR: tap_step = tms ? tap_pkg::UPDATE_IR : tap_pkg::PAUSE_IR;
      tap_pkg::PAUSE_IR: tap_step = tms ? tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
      tap_pkg::EXIT2_IR: tap_step = tms ? tap_pkg::UPDATE_IR : tap_pkg::SHIFT_IR;
      tap_pkg::UPDATE_IR: tap_step = tms ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
    endcase
  endfunction : tap_step

  // tap and scan registers
  always_comb begin
    next_tck_d = js.tck;
    next_state = state;
    next_ir_sh = ir_sh;
    next_ir = ir;
    next_ctl_sh = ctl_sh;
    next_emu_dir = emu_dir;
    next_byp = byp;
    next_tdo = tdo;
    next_tdo_en = tdo_en;
    if (!js.trst) begin
      // held in reset, so test clock activity cannot disturb functional mode
      next_state = tap_pkg::TEST_LOGIC_RESET;
      next_ir = tap_pkg::IR_RESET;
      next_emu_dir = tap_pkg::EMUCTL_RESET;
      next_tdo_en = 1'b0;
    end else begin
      if (tck_rise) begin
        next_state = tap_step(state, js.tms);
        unique case (state)
          tap_pkg::TEST_LOGIC_RESET: begin
            next_ir = tap_pkg::IR_RESET;
            next_emu_dir = tap_pkg::EMUCTL_RESET;
          end
          tap_pkg::CAPTURE_IR: next_ir_sh = tap_pkg::IR_CAPTURE;
          tap_pkg::SHIFT_IR: next_ir_sh = {js.tdi, ir_sh[tap_pkg::IR_LEN-1:1]};
          tap_pkg::UPDATE_IR: next_ir = ir_sh;
          tap_pkg::CAPTURE_DR: begin
            next_byp = 1'b0;
            next_ctl_sh = emu_dir;
          end
          tap_pkg::SHIFT_DR: begin
            if (ir == tap_pkg::IR_EMUCTL) begin
              next_ctl_sh = {js.tdi, ctl_sh[tap_pkg::EMUCTL_LEN-1:1]};
            end else begin
              next_byp = js.tdi;
            end
          end
          tap_pkg::UPDATE_DR: begin
            if (ir == tap_pkg::IR_EMUCTL) begin
              next_emu_dir = ctl_sh;
            end
          end
          default: begin
          end
        endcase
      end
      if (tck_fall) begin
        // enable follows the shift states only, so the pin floats outside a scan
        next_tdo_en = (state == tap_pkg::SHIFT_IR) || (state == tap_pkg::SHIFT_DR);
        if (state == tap_pkg::SHIFT_IR) begin
          next_tdo = ir_sh[0];
        end else if (ir == tap_pkg::IR_EMUCTL) begin
          next_tdo = ctl_sh[0];
        end else begin
          next_tdo = byp;
        end
      end
    end
    if (rst) begin
      next_tck_d = 1'b0;
      next_state = tap_pkg::TEST_LOGIC_RESET;
      next_ir_sh = tap_pkg::IR_RESET;
      next_ir = tap_pkg::IR_RESET;
      next_ctl_sh = tap_pkg::EMUCTL_RESET;
      next_emu_dir = tap_pkg::EMUCTL_RESET;
      next_byp = 1'b0;
      next_tdo = 1'b0;
      next_tdo_en = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    tck_d <= next_tck_d;
    state <= next_state;
    ir_sh <= next_ir_sh;
    ir <= next_ir;
    ctl_sh <= next_ctl_sh;
    emu_dir <= next_emu_dir;
    byp <= next_byp;
    tdo <= next_tdo;
    tdo_en <= next_tdo_en;
  end

  // pin drivers; every output is registered
  always_comb begin
    next_outputs_off = ~js.trst & e0s & ~e1s;
    next_scan_active = js.trst;
    next_emu_event_in = 2'h0;
    next_e0_o = 1'b0;
    next_e0_oe = 1'b0;
    next_e1_o = 1'b0;
    next_e1_oe = 1'b0;
    if (js.trst) begin
      // direction bit 1 drives the pin as an event output, 0 listens to the emulator
      next_e0_oe = emu_dir[0];
      next_e0_o = emu_event_out[0];
      next_e1_oe = emu_dir[1];
      next_e1_o = emu_event_out[1];
      next_emu_event_in = {emu_dir[1] ? 1'b0 : e1s, emu_dir[0] ? 1'b0 : e0s};
    end
    if (next_outputs_off) begin
      next_e0_oe = 1'b0;
      next_e1_oe = 1'b0;
    end
    if (rst) begin
      next_outputs_off = 1'b0;
      next_scan_active = 1'b0;
      next_emu_event_in = 2'h0;
      next_e0_oe = 1'b0;
      next_e1_oe = 1'b0;
      next_e0_o = 1'b0;
      next_e1_o = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    outputs_off <= next_outputs_off;
    scan_active <= next_scan_active;
    emu_event_in <= next_emu_event_in;
    emulator_event_pin_zero_o <= next_e0_o;
    emulator_event_pin_zero_oe <= next_e0_oe;
    emulator_event_pin_one_o <= next_e1_o;
    emulator_event_pin_one_oe <= next_e1_oe;
    tdo_o <= tdo;
    // next value, so data out lets go on the same edge as the emulator pins
    tdo_oe <= tdo_en & ~next_outputs_off;
  end
endmodule : jtag_emulation_test_port

// ==== tap_checker.sv ====
// assertions on the access port pins
`timescale 1ns/100ps
module tap_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire tap_pkg::jtag_in_t jtag_in,
  input wire logic emulator_event_pin_zero_in,
  input wire logic emulator_event_pin_one_in,
  input wire logic [1:0] emu_event_out,
  input wire logic tdo_o,
  input wire logic tdo_oe,
  input wire logic emulator_event_pin_zero_o,
  input wire logic emulator_event_pin_zero_oe,
  input wire logic emulator_event_pin_one_oe,
  input wire logic outputs_off,
  input wire logic scan_active
);
  wire logic off_req = !jtag_in.trst && emulator_event_pin_zero_in && !emulator_event_pin_one_in;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_off_floats: assert property (outputs_off |-> !tdo_oe && !emulator_event_pin_zero_oe &&
    !emulator_event_pin_one_oe) else $error("driver on while off");
  a_off_cause: assert property ($rose(outputs_off) |-> $past(off_req, 3)) else $error("off without cause");
  a_off_holds: assert property (off_req [*5] |-> outputs_off) else $error("off missed");
  a_off_clear: assert property (!off_req [*5] |-> !outputs_off) else $error("off stuck");
  a_scan_follow: assert property (jtag_in.trst [*5] |-> scan_active) else $error("scan not active");
  a_pins_float: assert property (!scan_active && !$past(scan_active) |->
    !emulator_event_pin_zero_oe && !emulator_event_pin_one_oe) else $error("pin driven in functional mode");
  a_tdo_on_fall: assert property ($changed(tdo_o) |-> !jtag_in.tck) else $error("data out moved on high clock");
  a_oe_on_fall: assert property ($changed(tdo_oe) && scan_active && !outputs_off |-> !jtag_in.tck)
    else $error("data out enable moved on high clock");
  a_pin_drive: assert property (emulator_event_pin_zero_oe |->
    emulator_event_pin_zero_o == $past(emu_event_out[0])) else $error("pin zero level wrong");
endmodule : tap_checker
bind jtag_emulation_test_port tap_checker chk (.mclk(mclk), .rst(rst), .jtag_in(jtag_in),
  .emulator_event_pin_zero_in(emulator_event_pin_zero_in), .emulator_event_pin_one_in(emulator_event_pin_one_in),
  .emu_event_out(emu_event_out), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
  .emulator_event_pin_zero_o(emulator_event_pin_zero_o), .emulator_event_pin_zero_oe(emulator_event_pin_zero_oe),
  .emulator_event_pin_one_oe(emulator_event_pin_one_oe), .outputs_off(outputs_off), .scan_active(scan_active));

// ==== scan_ctrl.sv ====
// external scan controller: free running test clock, mode and data drive, result capture
`timescale 1ns/100ps
module scan_ctrl (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    #3.1;
    forever #62.5 tck = ~tck;
  end
  // change on the falling edge so the device sees settled levels at the rise
  task automatic step(input logic m, input logic t, output logic q);
    @(negedge tck);
    tms = m;
    tdi = t;
    @(posedge tck);
    q = tdo;
  endtask : step
  // from reset or idle: lsb first, ends back in idle
  task automatic scan(input logic ir, input int n, input logic [3:0] din, output logic [3:0] dout);
    logic q;
    step(1'b0, 1'b0, q);
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    dout = 4'h0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan
endmodule : scan_ctrl

// ==== tb.sv ====
// testbench for the test and emulation access port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic trst = 1'b0;
  logic e0 = 1'b0;
  logic e1 = 1'b1;
  logic tdo_last = 1'b0;
  logic [1:0] ev_out = 2'h0;
  logic tck, tms, tdi, tdo_o, tdo_oe, p0_o, p0_oe, p1_o, p1_oe, off, scan;
  logic [1:0] ev_in;
  logic [3:0] d;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  // a released line shows the inverse of its last level, never a stale copy
  wire logic tdo_line = (tdo_oe === 1'b1) ? tdo_o : ~tdo_last;
  wire logic pin_zero_line = p0_oe ? p0_o : e0;
  wire logic pin_one_line = p1_oe ? p1_o : e1;
  always #4 mclk = ~mclk;
  scan_ctrl ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
  jtag_emulation_test_port uut (.mclk(mclk), .rst(rst), .jtag_in({tck, tms, tdi, trst}),
    .emulator_event_pin_zero_in(pin_zero_line), .emulator_event_pin_one_in(pin_one_line),
    .emu_event_out(ev_out), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .emulator_event_pin_zero_o(p0_o),
    .emulator_event_pin_zero_oe(p0_oe), .emulator_event_pin_one_o(p1_o), .emulator_event_pin_one_oe(p1_oe),
    .emu_event_in(ev_in), .outputs_off(off), .scan_active(scan));
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  always @(posedge mclk) begin
    tdo_last <= tdo_line;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run;
    end
  end
  task automatic settle(input logic t, input logic a, input logic b);
    @(posedge mclk);
    trst <= t;
    e0 <= a;
    e1 <= b;
    repeat (8) @(posedge mclk);
  endtask : settle
  task automatic t_off;
    for (int i = 0; i < 8; i++) begin
      settle(i[2], i[1], i[0]);
      `CHK("outputs_off", !i[2] && i[1] && !i[0], off)
      `CHK("scan_active", i[2], scan)
      if (!i[2] && i[1] && !i[0]) `CHK("oe", 3'h0, {tdo_oe, p0_oe, p1_oe})
    end
  endtask : t_off
  task automatic t_ignore;
    settle(1'b0, 1'b0, 1'b1);
    ctrl.scan(1'b1, 4, tap_pkg::IR_EMUCTL, d);
    ctrl.scan(1'b0, 2, 4'h3, d);
    repeat (8) @(posedge mclk);
    `CHK("idle pins", 3'h0, {tdo_oe, p0_oe, p1_oe})
    // a scan taken while in functional mode would leave the pins driving here
    settle(1'b1, 1'b0, 1'b1);
    `CHK("no direction kept", 2'h0, {p1_oe, p0_oe})
  endtask : t_ignore
  task automatic t_direction;
    settle(1'b1, 1'b0, 1'b1);
    ev_out <= 2'h2;
    ctrl.scan(1'b1, 4, tap_pkg::IR_EMUCTL, d);
    `CHK("ir capture", tap_pkg::IR_CAPTURE, d)
    ctrl.scan(1'b0, 2, 4'h3, d);
    repeat (8) @(posedge mclk);
    `CHK("pin oe", 2'h3, {p1_oe, p0_oe})
    `CHK("pin out", 2'h2, {p1_o, p0_o})
    `CHK("tdo idle", 1'b0, tdo_oe)
    ctrl.scan(1'b0, 2, 4'h0, d);
    settle(1'b1, 1'b1, 1'b0);
    `CHK("event in", 2'h1, ev_in)
    `CHK("no off in scan", 1'b0, off)
    settle(1'b1, 1'b0, 1'b1);
    `CHK("event in one", 2'h2, ev_in)
  endtask : t_direction
  task automatic t_bypass;
    ctrl.scan(1'b1, 4, tap_pkg::IR_BYPASS, d);
    `CHK("ir capture", tap_pkg::IR_CAPTURE, d)
    ctrl.scan(1'b0, 4, 4'hD, d);
    `CHK("bypass out", 4'hA, d)
  endtask : t_bypass
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_off;
    t_ignore;
    t_direction;
    t_bypass;
    complete_run;
  end
endmodule : tb
